// ==== hw/mfd_pkg.sv ====
// constants, types and helper functions of the memory fault and domain checker
package mfd_pkg;
	localparam logic [7:0]  OFF_DOMAIN     = 8'h00;
	localparam logic [7:0]  OFF_CTRL       = 8'h04;
	localparam logic [7:0]  OFF_TTB        = 8'h08;
	localparam logic [7:0]  OFF_FSTAT      = 8'h0c;
	localparam logic [7:0]  OFF_FADDR      = 8'h10;
	localparam int          CTRL_ALIGN_BIT = 1;
	localparam int          CTRL_SYS_BIT   = 8;
	localparam logic [31:0] DOMAIN_RST     = 32'h0000_0000;
	localparam logic [17:0] TTB_RST        = 18'h0_0000;
	localparam logic        CTRL_ALIGN_RST = 1'b0;
	localparam logic        CTRL_SYS_RST   = 1'b0;
	localparam int          TTB_LSB        = 14;
	localparam int          STAT_DOM_LSB   = 4;
	localparam logic [3:0]  SRC_WBUF       = 4'h0;
	localparam logic [3:0]  SRC_ALIGN      = 4'h1;
	localparam logic [3:0]  SRC_LF_SEC     = 4'h4;
	localparam logic [3:0]  SRC_TRANS_SEC  = 4'h5;
	localparam logic [3:0]  SRC_LF_PAGE    = 4'h6;
	localparam logic [3:0]  SRC_TRANS_PAGE = 4'h7;
	localparam logic [3:0]  SRC_BUS_SEC    = 4'h8;
	localparam logic [3:0]  SRC_DOM_SEC    = 4'h9;
	localparam logic [3:0]  SRC_BUS_PAGE   = 4'ha;
	localparam logic [3:0]  SRC_DOM_PAGE   = 4'hb;
	localparam logic [3:0]  SRC_WALK_L1    = 4'hc;
	localparam logic [3:0]  SRC_PERM_SEC   = 4'hd;
	localparam logic [3:0]  SRC_WALK_L2    = 4'he;
	localparam logic [3:0]  SRC_PERM_PAGE  = 4'hf;
	localparam logic [1:0]  L1_PAGE        = 2'b01;
	localparam logic [1:0]  L1_SECTION     = 2'b10;
	localparam logic [1:0]  L2_LARGE       = 2'b01;
	localparam logic [1:0]  L2_SMALL       = 2'b10;
	localparam logic [1:0]  DOM_NONE       = 2'b00;
	localparam logic [1:0]  DOM_CLIENT     = 2'b01;
	localparam logic [1:0]  DOM_RSVD       = 2'b10;
	localparam logic [1:0]  DOM_MANAGER    = 2'b11;
	localparam logic [1:0]  PERM_NONE      = 2'b00;
	localparam logic [1:0]  PERM_SUPER     = 2'b01;
	localparam logic [1:0]  PERM_USER_RO   = 2'b10;
	localparam logic [1:0]  PERM_FULL      = 2'b11;
	localparam int          L1_DOM_LSB     = 5;
	localparam int          SEC_PERM_LSB   = 10;
	localparam int          L2_PERM_IDX0   = 2;
	localparam logic [1:0]  SYNC_LAT       = 2'd3;
	typedef enum logic [2:0] {MFD_IDLE, MFD_START, MFD_L1, MFD_L2, MFD_CHECK, MFD_MEM, MFD_SETTLE} mfd_state_e;
	// a descriptor type of 00 or 11 is invalid at both levels
	function automatic logic mfd_valid(input logic [1:0] t);
		return (t == 2'b01) || (t == 2'b10);
	endfunction
	// 2-bit field number idx of a 32-bit word
	function automatic logic [1:0] mfd_fld2(input logic [31:0] v, input logic [3:0] idx);
		return v[{idx, 1'b0} +: 2];
	endfunction
	// byte-lane merge of a bus write
	function automatic logic [31:0] mfd_wmerge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
			if (sel[b])
				r[8*b +: 8] = nw[8*b +: 8];
		return r;
	endfunction
endpackage

// ==== hw/mfd_access_check.sv ====
// domain and access permission decision for one access
`timescale 1ns/1ps
module mfd_access_check
	import mfd_pkg::*;
(
	input  wire logic [1:0] dom_ctl_i,
	input  wire logic [1:0] perm_i,
	input  wire logic       sys_i,
	input  wire logic       user_i,
	input  wire logic       write_i,
	output logic            domain_fault_o,
	output logic            perm_fault_o
);
	logic allowed;

	always_comb
	begin
		allowed = 1'b0;
		case (perm_i)
			PERM_NONE:    allowed = sys_i && !user_i && !write_i;
			PERM_SUPER:   allowed = !user_i;
			PERM_USER_RO: allowed = !user_i || !write_i;
			PERM_FULL:    allowed = 1'b1;
			default:    allowed = 1'b0;
		endcase
	end

	always_comb
	begin
		domain_fault_o = 1'b0;
		perm_fault_o   = 1'b0;
		case (dom_ctl_i)
			DOM_NONE:    domain_fault_o = 1'b1;
			DOM_CLIENT:  perm_fault_o   = !allowed;
			DOM_RSVD:    domain_fault_o = 1'b1;
			DOM_MANAGER: perm_fault_o   = 1'b0;
			default:     domain_fault_o = 1'b1;
		endcase
	end
endmodule // mfd_access_check

// ==== hw/mfd_top.sv ====
// table walk, fault detection and fault reporting with wishbone registers
//
// The register addresses and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ps
module mfd_top
	import mfd_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic             wb_ack_o,
	output logic [31:0]      wb_dat_o,
	input  wire logic        cpu_req_i,
	input  wire logic [31:0] cpu_va_i,
	input  wire logic        cpu_we_i,
	input  wire logic        cpu_user_i,
	input  wire logic        cpu_instr_i,
	input  wire logic        cpu_word_i,
	input  wire logic        cpu_linefetch_i,
	output logic             cpu_ready_o,
	output logic             cpu_done_o,
	output logic             cpu_dabort_o,
	output logic             cpu_pabort_o,
	output logic [31:0]      cpu_pa_o,
	output logic             desc_req_o,
	output logic [31:0]      desc_addr_o,
	input  wire logic        desc_ack_i,
	input  wire logic        desc_err_i,
	input  wire logic [31:0] desc_data_i,
	output logic             mem_req_o,
	output logic [31:0]      mem_addr_o,
	output logic             mem_we_o,
	input  wire logic        mem_ack_i,
	input  wire logic        ext_abort_i,
	input  wire logic        wbuf_err_i
);
	typedef struct packed {
		mfd_state_e  state;
		logic [31:0] dac;
		logic        ctrl_align;
		logic        ctrl_sys;
		logic [17:0] ttb;
		logic [3:0]  fsrc;
		logic [3:0]  fdom;
		logic [31:0] faddr;
		logic        wb_ack;
		logic [31:0] wb_dat;
		logic [1:0]  sync1;
		logic [1:0]  sync2;
		logic [1:0]  sync3;
		logic [1:0]  lvl;
		logic        wbuf_prev;
		logic        wbuf_pend;
		logic [31:0] va;
		logic        we;
		logic        user;
		logic        instr;
		logic        word;
		logic        lf;
		logic [31:0] l1;
		logic [31:0] l2;
		logic        is_page;
		logic        ext_seen;
		logic [1:0]  cnt;
		logic        desc_req;
		logic [31:0] desc_addr;
		logic        mem_req;
		logic [31:0] mem_addr;
		logic        mem_we;
		logic        ready;
		logic        done;
		logic        dabort;
		logic        pabort;
		logic [31:0] pa;
	} mfd_regs_s;

	mfd_regs_s   s;
	mfd_regs_s   next_s;
	logic [1:0]  dom_ctl;
	logic [1:0]  perm_sel;
	logic [3:0]  perm_idx;
	logic        dom_fault;
	logic        perm_fault;
	logic        bus_req;
	logic        ab_now;
	logic [3:0]  ab_src;
	logic [3:0]  ab_dom;
	logic [31:0] wdata;
	logic [31:0] ctrl_word;

	// domain chosen by level-one bits 8:5, field n at bits 2n+1:2n
	assign dom_ctl = mfd_fld2(s.dac, s.l1[L1_DOM_LSB +: 4]);
	// sub-page quarter: va 11:10 for small pages, 15:14 for large
	assign perm_idx = (s.l2[1:0] == L2_LARGE) ? {2'b00, s.va[15:14]} + 4'(L2_PERM_IDX0)
	                                         : {2'b00, s.va[11:10]} + 4'(L2_PERM_IDX0);
	assign perm_sel = s.is_page ? mfd_fld2(s.l2, perm_idx) : s.l1[SEC_PERM_LSB +: 2];
	assign ctrl_word = (32'(s.ctrl_sys) << CTRL_SYS_BIT) | (32'(s.ctrl_align) << CTRL_ALIGN_BIT);
	assign bus_req = wb_cyc_i && wb_stb_i;

	mfd_access_check u_check (
		.dom_ctl_i      (dom_ctl),
		.perm_i         (perm_sel),
		.sys_i          (s.ctrl_sys),
		.user_i         (s.user),
		.write_i        (s.we),
		.domain_fault_o (dom_fault),
		.perm_fault_o   (perm_fault)
	);

	always_comb
	begin
		next_s = s;
		ab_now = 1'b0;
		ab_src = SRC_WBUF;
		ab_dom = 4'h0;
		wdata  = 32'h0000_0000;
		next_s.done   = 1'b0;
		next_s.dabort = 1'b0;
		next_s.pabort = 1'b0;

		// wishbone slave: ack one cycle after request, write lands when ack is seen
		next_s.wb_ack = bus_req && !s.wb_ack;
		if (bus_req && !s.wb_ack)
		begin
			case (wb_adr_i)
				OFF_DOMAIN: next_s.wb_dat = s.dac;
				OFF_CTRL:   next_s.wb_dat = ctrl_word;
				OFF_TTB:    next_s.wb_dat = {s.ttb, 14'h0000};
				OFF_FSTAT:  next_s.wb_dat = {24'h00_0000, s.fdom, s.fsrc};
				OFF_FADDR:  next_s.wb_dat = s.faddr;
				default:    next_s.wb_dat = 32'h0000_0000;
			endcase
		end
		if (bus_req && s.wb_ack && wb_we_i)
		begin
			case (wb_adr_i)
				OFF_DOMAIN: next_s.dac = mfd_wmerge(s.dac, wb_dat_i, wb_sel_i);
				OFF_CTRL:
				begin
					wdata = mfd_wmerge(ctrl_word, wb_dat_i, wb_sel_i);
					next_s.ctrl_align = wdata[CTRL_ALIGN_BIT];
					next_s.ctrl_sys   = wdata[CTRL_SYS_BIT];
				end
				OFF_TTB:
				begin
					wdata = mfd_wmerge({s.ttb, 14'h0000}, wb_dat_i, wb_sel_i);
					next_s.ttb = wdata[31:TTB_LSB];
				end
				default: wdata = 32'h0000_0000;
			endcase
		end

		// pin synchronisers; a level changes once stages two and three agree
		next_s.sync1 = {wbuf_err_i, ext_abort_i};
		next_s.sync2 = s.sync1;
		next_s.sync3 = s.sync2;
		for (int i = 0; i < 2; i++)
			if (s.sync2[i] == s.sync3[i])
				next_s.lvl[i] = s.sync3[i];
		next_s.wbuf_prev = s.lvl[1];

		case (s.state)
			MFD_IDLE:
			begin
				if (cpu_req_i)
				begin
					next_s.va    = cpu_va_i;
					next_s.we    = cpu_we_i;
					next_s.user  = cpu_user_i;
					next_s.instr = cpu_instr_i;
					next_s.word  = cpu_word_i;
					next_s.lf    = cpu_linefetch_i;
					next_s.ready = 1'b0;
					next_s.state = MFD_START;
				end
			end
			MFD_START:
			begin
				next_s.is_page  = 1'b0;
				next_s.ext_seen = 1'b0;
				if (s.wbuf_pend && !s.instr)
				begin
					// buffered write error lands on the first data access that can abort
					ab_now = 1'b1;
					ab_src = SRC_WBUF;
				end
				else if (s.ctrl_align && !s.instr && s.word && (s.va[1:0] != 2'b00))
				begin
					ab_now = 1'b1;
					ab_src = SRC_ALIGN;
				end
				else
				begin
					next_s.desc_req  = 1'b1;
					next_s.desc_addr = {s.ttb, s.va[31:20], 2'b00};
					next_s.state     = MFD_L1;
				end
			end
			MFD_L1:
			begin
				if (desc_ack_i)
				begin
					next_s.desc_req = 1'b0;
					next_s.l1       = desc_data_i;
					if (desc_err_i)
					begin
						ab_now = 1'b1;
						ab_src = SRC_WALK_L1;
					end
					else if (!mfd_valid(desc_data_i[1:0]))
					begin
						// the domain bits of an invalid entry are reported as they are
						ab_now = 1'b1;
						ab_src = SRC_TRANS_SEC;
						ab_dom = desc_data_i[L1_DOM_LSB +: 4];
					end
					else if (desc_data_i[1:0] == L1_PAGE)
					begin
						next_s.is_page   = 1'b1;
						next_s.desc_req  = 1'b1;
						next_s.desc_addr = {desc_data_i[31:10], s.va[19:12], 2'b00};
						next_s.state     = MFD_L2;
					end
					else
						next_s.state = MFD_CHECK;
				end
			end
			MFD_L2:
			begin
				if (desc_ack_i)
				begin
					next_s.desc_req = 1'b0;
					next_s.l2       = desc_data_i;
					ab_dom          = s.l1[L1_DOM_LSB +: 4];
					if (desc_err_i)
					begin
						ab_now = 1'b1;
						ab_src = SRC_WALK_L2;
					end
					else if (!mfd_valid(desc_data_i[1:0]))
					begin
						ab_now = 1'b1;
						ab_src = SRC_TRANS_PAGE;
					end
					else
						next_s.state = MFD_CHECK;
				end
			end
			MFD_CHECK:
			begin
				ab_dom = s.l1[L1_DOM_LSB +: 4];
				// domain and permission faults are found before any memory cycle is started
				if (dom_fault)
				begin
					ab_now = 1'b1;
					ab_src = s.is_page ? SRC_DOM_PAGE : SRC_DOM_SEC;
				end
				else if (perm_fault)
				begin
					ab_now = 1'b1;
					ab_src = s.is_page ? SRC_PERM_PAGE : SRC_PERM_SEC;
				end
				else
				begin
					next_s.mem_req = 1'b1;
					next_s.mem_we  = s.we;
					if (!s.is_page)
						next_s.mem_addr = {s.l1[31:20], s.va[19:0]};
					else if (s.l2[1:0] == L2_SMALL)
						next_s.mem_addr = {s.l2[31:12], s.va[11:0]};
					else
						next_s.mem_addr = {s.l2[31:16], s.va[15:0]};
					next_s.state = MFD_MEM;
				end
			end
			MFD_MEM:
			begin
				// an external abort never cuts the running cycle short
				next_s.ext_seen = s.ext_seen || s.lvl[0];
				if (mem_ack_i)
				begin
					next_s.mem_req = 1'b0;
					next_s.cnt     = 2'd0;
					next_s.state   = MFD_SETTLE;
				end
			end
			MFD_SETTLE:
			begin
				// wait out the synchroniser so a late abort pin is still caught
				next_s.cnt = s.cnt + 2'd1;
				if (s.cnt == SYNC_LAT - 2'd1)
				begin
					ab_dom = s.l1[L1_DOM_LSB +: 4];
					if (s.ext_seen || s.lvl[0])
					begin
						ab_now = 1'b1;
						if (s.lf)
							ab_src = s.is_page ? SRC_LF_PAGE : SRC_LF_SEC;
						else
							ab_src = s.is_page ? SRC_BUS_PAGE : SRC_BUS_SEC;
					end
					else
					begin
						next_s.done  = 1'b1;
						next_s.pa    = s.mem_addr;
						next_s.ready = 1'b1;
						next_s.state = MFD_IDLE;
					end
				end
				else
					next_s.ext_seen = s.ext_seen || s.lvl[0];
			end
			default:
			begin
				next_s.state = MFD_IDLE;
				next_s.ready = 1'b1;
			end
		endcase

		// every access is checked afresh, so a masked abort other than a write buffer error shows again on restart
		if (ab_now)
		begin
			next_s.done   = 1'b1;
			next_s.pa     = 32'h0000_0000;
			next_s.dabort = !s.instr;
			next_s.pabort = s.instr;
			next_s.ready  = 1'b1;
			next_s.state  = MFD_IDLE;
			if (!s.instr)
			begin
				next_s.fsrc  = ab_src;
				next_s.fdom  = ab_dom;
				next_s.faddr = s.va;
			end
			if (ab_src == SRC_WBUF)
				next_s.wbuf_pend = 1'b0;
		end
		// a new write buffer error wins over its own consumption
		if (s.lvl[1] && !s.wbuf_prev)
			next_s.wbuf_pend = 1'b1;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			s            <= '0;
			s.state      <= MFD_IDLE;
			s.dac        <= DOMAIN_RST;
			s.ttb        <= TTB_RST;
			s.ctrl_align <= CTRL_ALIGN_RST;
			s.ctrl_sys   <= CTRL_SYS_RST;
			s.ready      <= 1'b1;
		end
		else
			s <= next_s;
	end

	assign wb_ack_o     = s.wb_ack;
	assign wb_dat_o     = s.wb_dat;
	assign cpu_ready_o  = s.ready;
	assign cpu_done_o   = s.done;
	assign cpu_dabort_o = s.dabort;
	assign cpu_pabort_o = s.pabort;
	assign cpu_pa_o     = s.pa;
	assign desc_req_o   = s.desc_req;
	assign desc_addr_o  = s.desc_addr;
	assign mem_req_o    = s.mem_req;
	assign mem_addr_o   = s.mem_addr;
	assign mem_we_o     = s.mem_we;
endmodule // mfd_top

// ==== bench/mfd_mem_model.sv ====
// descriptor and memory responder at the far side of the checker
`timescale 1ns/1ps
module mfd_mem_model
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        desc_req_i,
	input  wire logic [31:0] desc_addr_i,
	output logic             desc_ack_o,
	output logic             desc_err_o,
	output logic [31:0]      desc_data_o,
	input  wire logic        mem_req_i,
	output logic             mem_ack_o,
	input  wire logic [31:0] l1_i,
	input  wire logic [31:0] l2_i,
	input  wire logic [1:0]  err_i,
	input  wire logic        slow_i
);
	logic [2:0] dc;
	logic [2:0] mc;
	logic       lv2;
	// ttb bit 20 stays 0, so only second-level fetches set bit 20
	assign lv2 = desc_addr_i[20];
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			dc          <= 3'h0;
			mc          <= 3'h0;
			desc_ack_o  <= 1'h0;
			desc_err_o  <= 1'h0;
			desc_data_o <= 32'h0;
			mem_ack_o   <= 1'h0;
		end
		else
		begin
			desc_ack_o  <= 1'h0;
			desc_err_o  <= 1'h0;
			mem_ack_o   <= 1'h0;
			// released data bus inverts every cycle, so the last word does not stay on it
			desc_data_o <= ~desc_data_o;
			dc          <= (desc_req_i && !desc_ack_o) ? dc + 3'h1 : 3'h0;
			mc          <= (mem_req_i && !mem_ack_o) ? mc + 3'h1 : 3'h0;
			if (desc_req_i && !desc_ack_o && dc >= {1'h0, slow_i, slow_i})
			begin
				desc_ack_o  <= 1'h1;
				desc_err_o  <= err_i[lv2];
				// one entry answers every index: a fully replicated table
				desc_data_o <= lv2 ? l2_i : l1_i;
			end
			if (mem_req_i && !mem_ack_o && mc >= {1'h0, slow_i, slow_i})
				mem_ack_o <= 1'h1;
		end
	end
endmodule // mfd_mem_model

// ==== bench/mfd_top_asserts.sv ====
// port assertions for the fault checker
`timescale 1ns/1ps
module mfd_top_asserts
	import mfd_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic        wb_ack_o,
	input wire logic        cpu_req_i,
	input wire logic [31:0] cpu_va_i,
	input wire logic        cpu_instr_i,
	input wire logic        cpu_word_i,
	input wire logic        cpu_ready_o,
	input wire logic        cpu_done_o,
	input wire logic        cpu_dabort_o,
	input wire logic        cpu_pabort_o,
	input wire logic [31:0] cpu_pa_o,
	input wire logic        desc_req_o,
	input wire logic [31:0] desc_addr_o,
	input wire logic        desc_ack_i,
	input wire logic        mem_req_o,
	input wire logic        mem_ack_i
);
	logic al_en;
	logic ins_q;
	// sel lanes not watched: the bench writes ctrl as whole words
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			al_en <= 1'h0;
			ins_q <= 1'h0;
		end
		else
		begin
			if (wb_ack_o && wb_we_i && wb_adr_i == OFF_CTRL)
				al_en <= wb_dat_i[CTRL_ALIGN_BIT];
			if (cpu_req_i && cpu_ready_o)
				ins_q <= cpu_instr_i;
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack_once: assert property (p_ack_once) else $error("ack too long");
	property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
	a_ack_next: assert property (p_ack_next) else $error("ack missing");
	property p_take; cpu_req_i && cpu_ready_o |=> !cpu_ready_o; endproperty
	a_take: assert property (p_take) else $error("ready held");
	property p_align; cpu_req_i && cpu_ready_o && al_en && !cpu_instr_i && cpu_word_i && cpu_va_i[1:0] != 2'h0
		|=> !desc_req_o ##1 cpu_done_o && cpu_dabort_o && !mem_req_o; endproperty
	a_align: assert property (p_align) else $error("alignment abort");
	property p_kind; cpu_done_o && (cpu_dabort_o || cpu_pabort_o) |-> cpu_pabort_o == ins_q && cpu_pa_o == 32'h0;
	endproperty
	a_kind: assert property (p_kind) else $error("abort kind");
	property p_flags; cpu_dabort_o || cpu_pabort_o |-> cpu_done_o && !(cpu_dabort_o && cpu_pabort_o); endproperty
	a_flags: assert property (p_flags) else $error("abort flags");
	property p_desc_hold; desc_req_o && !desc_ack_i |=> desc_req_o && $stable(desc_addr_o); endproperty
	a_desc_hold: assert property (p_desc_hold) else $error("fetch dropped");
	property p_mem_hold; mem_req_o && !mem_ack_i |=> mem_req_o; endproperty
	a_mem_hold: assert property (p_mem_hold) else $error("memory cycle cut");
	property p_done; cpu_req_i && cpu_ready_o |-> ##[2:60] cpu_done_o; endproperty
	a_done: assert property (p_done) else $error("no done");
	property p_idle; cpu_ready_o |-> !mem_req_o && !desc_req_o; endproperty
	a_idle: assert property (p_idle) else $error("bus busy when idle");
	c_dab: cover property (cpu_done_o && cpu_dabort_o);
	c_pab: cover property (cpu_done_o && cpu_pabort_o);
	c_mem: cover property (mem_req_o && mem_ack_i);
endmodule // mfd_top_asserts
bind mfd_top mfd_top_asserts mfd_top_asserts_inst (.*);

// ==== bench/testbench.sv ====
// self-checking bench of the fault checker
`timescale 1ns/1ps
module testbench
	import mfd_pkg::*;
;
	logic        clk_i = '0, rst_i = '1, wb_cyc_i = '0, wb_stb_i = '0, wb_we_i = '0;
	logic [7:0]  wb_adr_i = '0;
	logic [3:0]  wb_sel_i = '0;
	logic [31:0] wb_dat_i = '0, cpu_va_i = '0, wb_dat_o, cpu_pa_o, desc_addr_o, desc_data_i, mem_addr_o;
	logic        cpu_req_i = '0, cpu_we_i = '0, cpu_user_i = '0, cpu_instr_i = '0, cpu_word_i = '0;
	logic        cpu_linefetch_i = '0, ext_abort_i = '0, wbuf_err_i = '0, slow = '0;
	logic        wb_ack_o, cpu_ready_o, cpu_done_o, cpu_dabort_o, cpu_pabort_o, desc_req_o;
	logic        desc_ack_i, desc_err_i, mem_req_o, mem_we_o, mem_ack_i, da, pb, ms, mw;
	logic [1:0]  err = '0;
	logic [31:0] l1 = '0, l2 = '0, rd, pa, ma, dq;
	int          fails = 0, tests_run = 0, cyc_n = 0;
	mfd_top mfd_top_inst (.*);
	mfd_mem_model mfd_mem_model_inst (.clk_i(clk_i), .rst_i(rst_i), .desc_req_i(desc_req_o),
		.desc_addr_i(desc_addr_o), .desc_ack_o(desc_ack_i), .desc_err_o(desc_err_i), .desc_data_o(desc_data_i),
		.mem_req_i(mem_req_o), .mem_ack_o(mem_ack_i), .l1_i(l1), .l2_i(l2), .err_i(err), .slow_i(slow));
	always #2 clk_i = ~clk_i;
	task wrap_up;
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// whole run needs a few hundred cycles
	always @(posedge clk_i)
	begin
		cyc_n++;
		if (cyc_n == 20000)
		begin
			fails++;
			wrap_up;
		end
	end
	task chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e)
		begin
			fails++;
			$display("wrong value at %0t: saw %h want %h", $time, s, e);
		end
	endtask
	task wbc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
		@(posedge clk_i);
		wb_cyc_i <= '1;
		wb_stb_i <= '1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= s;
		do @(posedge clk_i); while (wb_ack_o !== 1'h1);
		rd = wb_dat_o;
		wb_cyc_i <= '0;
		wb_stb_i <= '0;
	endtask
	task acc(input logic [31:0] va, input logic w, u, i, wd, lf);
		@(posedge clk_i);
		cpu_req_i <= '1;
		cpu_va_i <= va;
		cpu_we_i <= w;
		cpu_user_i <= u;
		cpu_instr_i <= i;
		cpu_word_i <= wd;
		cpu_linefetch_i <= lf;
		ms = '0;
		{mw, ma, dq} = '0;
		@(posedge clk_i);
		cpu_req_i <= '0;
		do
		begin
			@(posedge clk_i);
			ms = ms | mem_req_o;
			if (desc_req_o)
				dq = desc_addr_o;
			if (mem_req_o)
				{mw, ma} = {mem_we_o, mem_addr_o};
		end
		while (cpu_done_o !== 1'h1);
		da = cpu_dabort_o;
		pb = cpu_pabort_o;
		pa = cpu_pa_o;
	endtask
	task flt(input logic [7:0] f, input logic [31:0] va, input logic m);
		chk(da, 1);
		chk(ms, m);
		wbc(0, OFF_FSTAT, 0);
		chk(rd, {24'h0, f});
		wbc(0, OFF_FADDR, 0);
		chk(rd, va);
	endtask
	function automatic logic [31:0] sec(input logic [1:0] pm, input logic [3:0] dm);
		return {12'h123, 8'h00, pm, 1'h0, dm, 3'h0, L1_SECTION};
	endfunction
	task t_regs;
		chk(cpu_ready_o, 1);
		wbc(0, OFF_DOMAIN, 0);
		chk(rd, DOMAIN_RST);
		wbc(0, 8'h20, 0);
		chk(rd, 0);
		wbc(1, OFF_DOMAIN, 32'hffff_ffff);
		wbc(1, OFF_DOMAIN, 0, 4'h2);
		wbc(0, OFF_DOMAIN, 0);
		chk(rd, 32'hffff_00ff);
		wbc(1, OFF_TTB, 32'h4000_3fff);
		wbc(0, OFF_TTB, 0);
		chk(rd, 32'h4000_0000);
		$display("register test done");
	endtask
	task t_dom;
		logic [7:0] ex[3];
		ex = '{8'h59, 8'h5d, 8'h59};
		l1 = sec(PERM_USER_RO, 4'h5);
		for (int d = 0; d < 4; d++)
		begin
			wbc(1, OFF_DOMAIN, 32'(d) << 10);
			acc(32'h0004_5678, 1, 1, 0, 0, 0);
			if (d == 3)
			begin
				chk(pa, 32'h1234_5678);
				chk(ma, 32'h1234_5678);
				chk(mw, 1);
				chk(dq, 32'h4000_0000);
			end
			else
				flt(ex[d], 32'h0004_5678, 0);
		end
		$display("domain test done");
	endtask
	task t_page;
		slow = '1;
		wbc(1, OFF_DOMAIN, 32'h0000_0400);
		l1 = {22'h000400, 1'h0, 4'h5, 3'h0, L1_PAGE};
		l2 = {20'habcde, PERM_FULL, PERM_USER_RO, PERM_FULL, PERM_FULL, 2'h0, L2_SMALL};
		acc(32'h0000_3abc, 1, 1, 0, 0, 0);
		flt(8'h5f, 32'h0000_3abc, 0);
		acc(32'h0000_36bc, 1, 1, 0, 0, 0);
		chk(pa, 32'habcd_e6bc);
		chk(dq, 32'h0010_000c);
		chk(mw, 1);
		l2 = {16'h5678, 4'h0, 8'hff, 2'h0, L2_LARGE};
		acc(32'h0012_9abc, 0, 1, 0, 0, 0);
		chk(pa, 32'h5678_9abc);
		chk(ma, 32'h5678_9abc);
		chk(mw, 0);
		chk(dq, 32'h0010_00a4);
		l2[1:0] = 2'h0;
		acc(32'h0000_1000, 0, 0, 0, 0, 0);
		flt(8'h57, 32'h0000_1000, 0);
		wbc(1, OFF_DOMAIN, 0);
		l2[1:0] = L2_SMALL;
		acc(32'h0000_2000, 0, 0, 0, 0, 0);
		flt(8'h5b, 32'h0000_2000, 0);
		err = 2'h2;
		acc(32'h0000_3000, 0, 0, 0, 0, 0);
		flt(8'h5e, 32'h0000_3000, 0);
		err = 2'h1;
		acc(32'h0080_0000, 0, 0, 0, 0, 0);
		flt(8'h0c, 32'h0080_0000, 0);
		err = 2'h0;
		slow = '0;
		$display("page test done");
	endtask
	task t_sect;
		l1 = 32'h0000_01a0;
		acc(32'h0070_0000, 0, 0, 1, 0, 0);
		chk({da, pb}, 2'h1);
		chk(dq, 32'h4000_001c);
		wbc(0, OFF_FSTAT, 0);
		chk(rd, 32'h0000_000c);
		acc(32'h0070_0000, 0, 0, 0, 0, 0);
		flt(8'hd5, 32'h0070_0000, 0);
		wbc(1, OFF_CTRL, 32'h0000_0002);
		acc(32'h0000_1001, 0, 0, 0, 1, 0);
		flt(8'h01, 32'h0000_1001, 0);
		wbc(1, OFF_CTRL, 0);
		acc(32'h0000_1001, 0, 0, 0, 1, 0);
		flt(8'hd5, 32'h0000_1001, 0);
		wbc(1, OFF_CTRL, 32'h0000_0100);
		wbc(1, OFF_DOMAIN, 32'h0000_0400);
		l1 = sec(PERM_NONE, 4'h5);
		acc(32'h0004_5678, 0, 0, 0, 0, 0);
		chk(da, 0);
		chk(pa, 32'h1234_5678);
		acc(32'h0004_5678, 1, 0, 0, 0, 0);
		flt(8'h5d, 32'h0004_5678, 0);
		wbc(1, OFF_CTRL, 0);
		$display("section test done");
	endtask
	task t_ext;
		wbc(1, OFF_DOMAIN, 32'hffff_ffff);
		l1 = sec(PERM_NONE, 4'h5);
		ext_abort_i <= '1;
		for (int k = 0; k < 2; k++)
		begin
			acc(32'h0004_5678, 0, 0, 0, 0, k[0]);
			flt(k ? 8'h54 : 8'h58, 32'h0004_5678, 1);
		end
		ext_abort_i <= '0;
		repeat (6) @(posedge clk_i);
		wbuf_err_i <= '1;
		repeat (2) @(posedge clk_i);
		wbuf_err_i <= '0;
		repeat (6) @(posedge clk_i);
		acc(32'h0000_0040, 0, 0, 1, 0, 0);
		chk({da, pb}, 2'h0);
		acc(32'h0004_0040, 1, 0, 0, 0, 0);
		flt(8'h00, 32'h0004_0040, 0);
		acc(32'h0004_0040, 1, 0, 0, 0, 0);
		chk(da, 0);
		chk(pa, 32'h1234_0040);
		$display("external abort test done");
	endtask
	initial
	begin
		repeat (20) @(posedge clk_i);
		rst_i <= '0;
		t_regs;
		t_dom;
		t_page;
		t_sect;
		t_ext;
		wrap_up;
	end
endmodule // testbench
